// *** logic/csss_clock_select.sv ***
`timescale 1ns/10ps
`include "csss_map.svh"

module csss_clock_select
  import csss_pkg::*;
#(
  parameter int WDT_OSC_KHZ = `CSSS_WDT_OSC_KHZ,
  parameter int LONG_WDT_TICKS = `CSSS_T_LONG_MS * WDT_OSC_KHZ,
  parameter int WAKE_32K_CK = `CSSS_WAKE_32K_CK
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Non-volatile configuration.
  input wire logic fuse_valid,
  input wire logic [3:0] clock_source_select_fuses,
  input wire logic [1:0] startup_time_code,
  input wire logic divide_by_eight_fuse,
  input wire logic [7:0] factory_calibration_byte,
  // Oscillator and pin inputs, asynchronous to clk.
  input wire logic external_clock_input,
  input wire logic rc_osc_in,
  input wire logic lp128_osc_in,
  input wire logic watch_osc_in,
  input wire logic wdt_osc_in,
  // Sleep control from the power manager.
  input wire logic sleep_req,
  input wire logic wake_req,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Clock outputs.
  output logic core_clk_en,
  output logic wdt_tick,
  output logic [7:0] oscillator_trim_register,
  output csss_src_t selected_source,
  output logic core_released
);

  localparam int SHORT_WDT_TICKS = `CSSS_T_SHORT_MS * WDT_OSC_KHZ;
  localparam int NSRC = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detection.

  logic [NSRC-1:0] osc_raw;
  logic [NSRC-1:0] osc_s1_r;
  logic [NSRC-1:0] osc_s2_r;
  logic [NSRC-1:0] osc_s3_r;
  logic [NSRC-1:0] osc_edge;

  assign osc_raw = {wdt_osc_in, watch_osc_in, lp128_osc_in, rc_osc_in, external_clock_input};

  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (srst) begin
          osc_s1_r[gi] <= 1'b0;
          osc_s2_r[gi] <= 1'b0;
          osc_s3_r[gi] <= 1'b0;
        end else begin
          osc_s1_r[gi] <= osc_raw[gi];
          osc_s2_r[gi] <= osc_s1_r[gi];
          osc_s3_r[gi] <= osc_s2_r[gi];
        end
      end
      assign osc_edge[gi] = osc_s2_r[gi] & ~osc_s3_r[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Configuration capture.

  logic [3:0] eff_sel;
  logic [1:0] eff_stc;
  logic eff_div8;
  logic [3:0] sel_r;
  logic [1:0] stc_r;
  csss_src_t src_r;
  csss_src_t src_nxt;

  // A blank fuse array falls back to the shipped configuration.
  assign eff_sel = fuse_valid ? clock_source_select_fuses : `CSSS_FACTORY_SEL;
  assign eff_stc = fuse_valid ? startup_time_code : `CSSS_FACTORY_STC;
  assign eff_div8 = fuse_valid ? divide_by_eight_fuse : `CSSS_FACTORY_DIV8;

  always_comb begin
    if (eff_sel == `CSSS_SEL_EXT) begin
      src_nxt = SRC_EXT;
    end else if (eff_sel == `CSSS_SEL_LP128) begin
      src_nxt = SRC_LP128;
    end else if (eff_sel[3:1] == `CSSS_SEL_WATCH_HI) begin
      src_nxt = SRC_WATCH;
    end else begin
      // Unlisted codes run from the RC oscillator so the core never hangs.
      src_nxt = SRC_RC;
    end
  end

  // Fuses are sampled only while reset is held; they never change in flight.
  always_ff @(posedge clk) begin
    if (srst) begin
      sel_r <= eff_sel;
      stc_r <= eff_stc;
      src_r <= src_nxt;
    end
  end

  logic src_edge;
  logic wdt_edge;

  always_comb begin
    case (src_r)
      SRC_EXT: src_edge = osc_edge[0];
      SRC_RC: src_edge = osc_edge[1];
      SRC_LP128: src_edge = osc_edge[2];
      SRC_WATCH: src_edge = osc_edge[3];
      default: src_edge = osc_edge[1];
    endcase
  end

  // The watchdog side never follows the system source selection.
  assign wdt_edge = osc_edge[4];

  ////////////////////////////////////////////////////////////////////////////
  // Start-up delay selection.

  logic [15:0] reset_ticks;
  logic [15:0] wake_cycles;

  always_comb begin
    case (stc_r)
      `CSSS_STC_NONE: reset_ticks = 16'h0000;
      `CSSS_STC_SHORT: reset_ticks = 16'(SHORT_WDT_TICKS);
      // Reserved code 11 takes the longest delay, as does code 10.
      default: reset_ticks = 16'(LONG_WDT_TICKS);
    endcase
  end

  always_comb begin
    if (src_r == SRC_WATCH) begin
      wake_cycles = sel_r[0] ? 16'(WAKE_32K_CK) : `CSSS_WAKE_1K_CK;
    end else begin
      wake_cycles = `CSSS_WAKE_FAST_CK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start-up sequencer.

  csss_state_t state_r;
  csss_state_t state_nxt;
  logic ms_load;
  logic ck_load;
  logic [15:0] ck_load_val;
  logic [15:0] ms_count;
  logic [15:0] ck_count;
  logic ms_done;
  logic ck_done;

  always_comb begin
    state_nxt = state_r;
    ms_load = 1'b0;
    ck_load = 1'b0;
    ck_load_val = `CSSS_RESET_CK;
    case (state_r)
      ST_BOOT: begin
        ms_load = 1'b1;
        state_nxt = ST_RST_MS;
      end
      ST_RST_MS: begin
        if (ms_done) begin
          ck_load = 1'b1;
          state_nxt = ST_RST_CK;
        end
      end
      ST_RST_CK: begin
        if (ck_done) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sleep_req) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_req) begin
          ck_load = 1'b1;
          ck_load_val = wake_cycles;
          state_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (ck_done) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_BOOT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_BOOT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Reset time-out is timed by the watchdog oscillator, not the system source.
  csss_startup_counter #(.W(16)) u_ms_cnt (
    .clk(clk),
    .srst(srst),
    .load(ms_load),
    .load_val(reset_ticks),
    .step(wdt_edge),
    .count(ms_count),
    .done(ms_done)
  );

  csss_startup_counter #(.W(16)) u_ck_cnt (
    .clk(clk),
    .srst(srst),
    .load(ck_load),
    .load_val(ck_load_val),
    .step(src_edge),
    .count(ck_count),
    .done(ck_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator trim register.

  logic [7:0] trim_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      trim_r <= factory_calibration_byte;
    end else if (reg_wr && reg_addr == `CSSS_OFS_TRIM) begin
      trim_r <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System clock prescaler.

  logic [3:0] ps_field_r;
  logic pce_r;
  logic [1:0] pce_cnt_r;
  logic ps_wr;
  logic [7:0] div_cnt_r;
  logic [7:0] div_limit;
  logic div_tick;

  assign ps_wr = reg_wr && reg_addr == `CSSS_OFS_PRESCALE;

  // Changing the field takes an arming write first, so a stray write cannot
  // slow or speed the core.
  always_ff @(posedge clk) begin
    if (srst) begin
      ps_field_r <= eff_div8 ? `CSSS_PS_DIV8 : `CSSS_PS_DIV1;
      pce_r <= 1'b0;
      pce_cnt_r <= 2'h0;
    end else if (ps_wr && reg_wdata == `CSSS_PCE_ARM && !pce_r) begin
      pce_r <= 1'b1;
      pce_cnt_r <= `CSSS_PCE_CYCLES;
    end else if (ps_wr && pce_r && !reg_wdata[`CSSS_PCE_BIT]) begin
      ps_field_r <= reg_wdata[3:0];
      pce_r <= 1'b0;
    end else if (pce_r) begin
      pce_cnt_r <= pce_cnt_r - 2'h1;
      if (pce_cnt_r == 2'h0) begin
        pce_r <= 1'b0;
      end
    end
  end

  always_comb begin
    if (ps_field_r > `CSSS_PS_MAX) begin
      div_limit = 8'hff;
    end else begin
      div_limit = 8'((9'h001 << ps_field_r) - 9'h001);
    end
  end

  assign div_tick = src_edge && (div_cnt_r >= div_limit);

  // Restarting the divider on a field change avoids a runt period.
  always_ff @(posedge clk) begin
    if (srst || ps_wr) begin
      div_cnt_r <= 8'h00;
    end else if (div_tick) begin
      div_cnt_r <= 8'h00;
    end else if (src_edge) begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock outputs.

  logic core_clk_en_r;
  logic wdt_tick_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      core_clk_en_r <= 1'b0;
    end else begin
      core_clk_en_r <= div_tick && state_r == ST_RUN;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wdt_tick_r <= 1'b0;
    end else begin
      wdt_tick_r <= wdt_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port.

  logic [7:0] rdata_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `CSSS_OFS_TRIM: rdata_r <= trim_r;
        `CSSS_OFS_PRESCALE: rdata_r <= {pce_r, 3'h0, ps_field_r};
        `CSSS_OFS_STATUS: rdata_r <= {sel_r, state_r, state_r == ST_RUN};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = rdata_r;
  assign core_clk_en = core_clk_en_r;
  assign wdt_tick = wdt_tick_r;
  assign oscillator_trim_register = trim_r;
  assign selected_source = src_r;
  assign core_released = (state_r == ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  chk_trim_reset_load: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> trim_r == $past(factory_calibration_byte))
    else $error("trim register missed factory byte at reset");

  chk_trim_sw_write: assert property (@(posedge clk) disable iff (srst)
    (reg_wr && reg_addr == `CSSS_OFS_TRIM) |=> oscillator_trim_register == $past(reg_wdata))
    else $error("trim write did not reach oscillator");

  chk_gate_held: assert property (@(posedge clk) disable iff (srst)
    (state_r != ST_RUN) |=> !core_clk_en_r)
    else $error("core clock enabled before start-up ended");

  chk_wake_watch_1k: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_SLEEP && wake_req && src_r == SRC_WATCH && !sel_r[0]) |=> ck_count == 16'h0400)
    else $error("watch crystal wake delay not 1K");

  chk_wake_watch_32k: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_SLEEP && wake_req && src_r == SRC_WATCH && sel_r[0]) |=> ck_count == 16'(WAKE_32K_CK))
    else $error("watch crystal wake delay not 32K");

  chk_wake_rc_six: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_SLEEP && wake_req && src_r == SRC_RC) |=> ck_count == 16'h0006 ##1 state_r == ST_WAKE)
    else $error("rc wake delay not 6");

  chk_wake_lp_six: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_SLEEP && wake_req && src_r == SRC_LP128) |=> ck_count == 16'h0006)
    else $error("128k wake delay not 6");

  chk_wake_ext_six: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_SLEEP && wake_req && src_r == SRC_EXT) |=> ck_count == 16'h0006)
    else $error("external wake delay not 6");

  chk_reset_ck_14: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_RST_MS && ms_done) |=> state_r == ST_RST_CK && ck_count == 16'h000e)
    else $error("reset delay not 14 cycles");

  chk_reserved_long: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_BOOT && stc_r == 2'h3) |=> ms_count == 16'(LONG_WDT_TICKS))
    else $error("reserved start-up code not longest");

  chk_src_decode: assert property (@(posedge clk) disable iff (srst)
    (sel_r == `CSSS_SEL_RC) |-> src_r == SRC_RC && $stable(src_r))
    else $error("selector 0010 not rc");

  chk_src_lp: assert property (@(posedge clk) disable iff (srst)
    (sel_r == `CSSS_SEL_LP128) |-> src_r == SRC_LP128)
    else $error("selector 0011 not 128k");

  chk_src_ext: assert property (@(posedge clk) disable iff (srst)
    (sel_r == `CSSS_SEL_EXT) |-> src_r == SRC_EXT)
    else $error("selector 0000 not external");

  chk_ps_reset_val: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> ps_field_r == ($past(eff_div8) ? `CSSS_PS_DIV8 : `CSSS_PS_DIV1))
    else $error("prescaler reset value wrong");

  chk_factory_cfg: assert property (@(posedge clk) disable iff (srst)
    ($fell(srst) && !$past(fuse_valid)) |-> sel_r == 4'h2 && stc_r == 2'h2 && ps_field_r == 4'h3)
    else $error("factory default configuration wrong");

  chk_wdt_follow: assert property (@(posedge clk) disable iff (srst)
    (state_r == ST_RST_MS && !ms_done && !osc_edge[4]) |=> ms_count == $past(ms_count))
    else $error("reset time-out counted without watchdog edge");

  cov_reset_to_run: cover property (@(posedge clk) disable iff (srst)
    state_r == ST_RST_CK ##1 state_r == ST_RUN);

  cov_wake_done: cover property (@(posedge clk) disable iff (srst)
    state_r == ST_WAKE ##1 state_r == ST_RUN);

  cov_ps_change: cover property (@(posedge clk) disable iff (srst)
    pce_r && ps_wr && !reg_wdata[7]);

endmodule : csss_clock_select

// *** logic/csss_map.svh ***
`ifndef CSSS_MAP_SVH
`define CSSS_MAP_SVH

// Register offsets on the plain register port.
`define CSSS_OFS_STATUS 8'h60
`define CSSS_OFS_PRESCALE 8'h61
`define CSSS_OFS_TRIM 8'h66

// Clock source selector encodings.
`define CSSS_SEL_EXT 4'h0
`define CSSS_SEL_RC 4'h2
`define CSSS_SEL_LP128 4'h3
`define CSSS_SEL_WATCH_HI 3'h2

// Factory default configuration.
`define CSSS_FACTORY_SEL 4'h2
`define CSSS_FACTORY_STC 2'h2
`define CSSS_FACTORY_DIV8 1'b1

// Start-up time codes.
`define CSSS_STC_NONE 2'h0
`define CSSS_STC_SHORT 2'h1

// Prescaler field values and change procedure.
`define CSSS_PS_DIV1 4'h0
`define CSSS_PS_DIV8 4'h3
`define CSSS_PS_MAX 4'h8
`define CSSS_PCE_ARM 8'h80
`define CSSS_PCE_BIT 7
`define CSSS_PCE_CYCLES 2'h3

// Start-up figures, in source cycles or milliseconds, and the watchdog oscillator rate in kHz.
`define CSSS_WAKE_FAST_CK 16'h0006
`define CSSS_WAKE_1K_CK 16'h0400
`define CSSS_WAKE_32K_CK 32768
`define CSSS_RESET_CK 16'h000e
`define CSSS_T_SHORT_MS 4
`define CSSS_T_LONG_MS 65
`define CSSS_WDT_OSC_KHZ 128

`endif

// *** logic/csss_pkg.sv ***
package csss_pkg;

  typedef enum logic [1:0] {
    SRC_EXT,
    SRC_RC,
    SRC_LP128,
    SRC_WATCH
  } csss_src_t;

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_RST_MS,
    ST_RST_CK,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } csss_state_t;

endpackage : csss_pkg

// *** logic/csss_startup_counter.sv ***
`timescale 1ns/10ps

module csss_startup_counter #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Control.
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic step,
  // Status.
  output logic [W-1:0] count,
  output logic done
);

  logic [W-1:0] cnt_r;

  // Load wins over a step so that a fresh delay never loses its first edge.
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (step && cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  assign count = cnt_r;
  assign done = (cnt_r == '0);

endmodule : csss_startup_counter

// *** tb/csss_osc_model.sv ***
`timescale 1ns/10ps

module csss_osc_model #(
  parameter int EXT_HALF = 250,
  parameter int RC_HALF = 200,
  parameter int LP_HALF = 450,
  parameter int WATCH_HALF = 300,
  parameter int WDT_HALF = 1000
) (
  // Oscillator pins.
  output logic ext_pin,
  output logic rc_pin,
  output logic lp_pin,
  output logic watch_pin,
  output logic wdt_pin
);
  // Oscillators run free; odd start offsets keep them out of phase with clk and each other.
  // The external driver holds one period for the whole run, well inside the per-cycle drift limit.
  initial begin
    ext_pin = 1'b0;
    #13;
    forever #EXT_HALF ext_pin = ~ext_pin;
  end

  initial begin
    rc_pin = 1'b0;
    #29;
    forever #RC_HALF rc_pin = ~rc_pin;
  end

  initial begin
    lp_pin = 1'b0;
    #41;
    forever #LP_HALF lp_pin = ~lp_pin;
  end

  initial begin
    watch_pin = 1'b0;
    #7;
    forever #WATCH_HALF watch_pin = ~watch_pin;
  end

  initial begin
    wdt_pin = 1'b0;
    #53;
    forever #WDT_HALF wdt_pin = ~wdt_pin;
  end
endmodule : csss_osc_model

// *** tb/tb.sv ***
`timescale 1ns/10ps

module tb;
  import csss_pkg::*;
  // Short millisecond counts keep the run brief; ranges below stay disjoint.
  localparam int KHZ = 3;
  localparam int LONG = 30;
  localparam int W32 = 40;
  localparam logic [7:0] FACT = 8'h5a;
  // The last entry is an unlisted selector, which must fall back to the RC oscillator.
  localparam logic [3:0] T_SEL [6] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h0, 4'h1};
  localparam logic [1:0] T_STC [6] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h0, 2'h0};
  localparam csss_src_t T_SRC [6] = '{SRC_RC, SRC_LP128, SRC_WATCH, SRC_WATCH, SRC_EXT, SRC_RC};
  localparam int T_TICK [6] = '{4 * KHZ, LONG, LONG, 4 * KHZ, 0, 0};
  localparam int T_WAKE [6] = '{6, 6, 1024, W32, 6, 6};

  logic clk, srst, fuse_valid, divide_by_eight_fuse, sleep_req, wake_req, reg_wr, reg_rd;
  logic [3:0] clock_source_select_fuses;
  logic [1:0] startup_time_code;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, oscillator_trim_register, rd_val;
  logic ext_pin, rc_pin, lp_pin, watch_pin, wdt_pin, src_pin, core_clk_en, wdt_tick, core_released;
  csss_src_t selected_source, cur_src;
  int errors, check_count, ticks;

  ////////////////////////////////////////
  csss_osc_model i_csss_osc_model (.ext_pin(ext_pin), .rc_pin(rc_pin), .lp_pin(lp_pin),
    .watch_pin(watch_pin), .wdt_pin(wdt_pin));

  csss_clock_select #(.WDT_OSC_KHZ(KHZ), .LONG_WDT_TICKS(LONG), .WAKE_32K_CK(W32)) i_csss_clock_select (
    .clk(clk), .srst(srst), .fuse_valid(fuse_valid), .clock_source_select_fuses(clock_source_select_fuses),
    .startup_time_code(startup_time_code), .divide_by_eight_fuse(divide_by_eight_fuse),
    .factory_calibration_byte(FACT), .external_clock_input(ext_pin), .rc_osc_in(rc_pin),
    .lp128_osc_in(lp_pin), .watch_osc_in(watch_pin), .wdt_osc_in(wdt_pin), .sleep_req(sleep_req),
    .wake_req(wake_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_clk_en(core_clk_en), .wdt_tick(wdt_tick),
    .oscillator_trim_register(oscillator_trim_register), .selected_source(selected_source),
    .core_released(core_released));

  always_comb begin
    case (cur_src)
      SRC_EXT: src_pin = ext_pin;
      SRC_RC: src_pin = rc_pin;
      SRC_LP128: src_pin = lp_pin;
      default: src_pin = watch_pin;
    endcase
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic ok(input string name, input logic c);
    chk(name, {7'h00, c}, 8'h01);
  endtask : ok

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  // Counts rising source edges seen at the pin until the core is released.
  task automatic count_edges(output int e);
    int n;
    logic prev;
    e = 0;
    prev = src_pin;
    for (n = 0; n < 20000 && core_released !== 1'b1; n++) begin
      @(negedge clk);
      e += int'(src_pin && !prev);
      prev = src_pin;
    end
    if (n == 20000) begin
      ok("release timeout", 1'b0);
      conclude();
    end
  endtask : count_edges

  task automatic boot(input logic [3:0] sel, input logic [1:0] stc, input logic d8, input logic fv);
    int n;
    @(posedge clk);
    srst <= 1'b1;
    fuse_valid <= fv;
    clock_source_select_fuses <= sel;
    startup_time_code <= stc;
    divide_by_eight_fuse <= d8;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    ticks = 0;
    for (n = 0; n < 20000 && core_released !== 1'b1; n++) begin
      @(negedge clk);
      ticks += int'(wdt_tick === 1'b1);
    end
    if (n == 20000) begin
      ok("release timeout", 1'b0);
      conclude();
    end
  endtask : boot

  task automatic nap(input int w);
    int n, e;
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    repeat (3) @(negedge clk);
    ok("gated in sleep", core_released === 1'b0);
    e = 0;
    for (n = 0; n < 60; n++) begin
      @(negedge clk);
      e += int'(wdt_tick === 1'b1);
    end
    ok("watchdog ticks in sleep", e > 1);
    @(posedge clk);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    count_edges(e);
    ok("wake edges", e >= w - 1 && e <= w + 3);
  endtask : nap

  task automatic div_chk(input int d);
    int n, e, p;
    logic prev;
    e = 0;
    p = 0;
    prev = src_pin;
    for (n = 0; n < 2000 && e < 64; n++) begin
      @(negedge clk);
      e += int'(src_pin && !prev);
      p += int'(core_clk_en === 1'b1);
      prev = src_pin;
    end
    if (n == 2000) begin
      ok("edge timeout", 1'b0);
      conclude();
    end
    ok("core enables", p >= 64 / d - 1 && p <= 64 / d + 1);
  endtask : div_chk

  ////////////////////////////////////////
  task automatic factory;
    cur_src = SRC_RC;
    boot(4'h0, 2'h0, 1'b0, 1'b0);
    chk("source", 8'(selected_source), 8'(SRC_RC));
    ok("reset ticks", ticks >= LONG && ticks <= LONG + 8);
    chk("trim", oscillator_trim_register, FACT);
    rd(8'h61, rd_val);
    chk("prescaler", rd_val, 8'h03);
    rd(8'h60, rd_val);
    chk("status", rd_val, 8'h27);
    div_chk(8);
  endtask : factory

  task automatic trim_ext;
    wr(8'h66, 8'ha5);
    @(negedge clk);
    chk("trim write", oscillator_trim_register, 8'ha5);
    rd(8'h66, rd_val);
    chk("trim read", rd_val, 8'ha5);
    rd(8'h70, rd_val);
    chk("unmapped read", rd_val, 8'h00);
    cur_src = SRC_EXT;
    boot(4'h0, 2'h0, 1'b0, 1'b1);
    chk("trim after reset", oscillator_trim_register, FACT);
    rd(8'h61, rd_val);
    chk("prescaler", rd_val, 8'h00);
    div_chk(1);
  endtask : trim_ext

  task automatic sources;
    for (int i = 0; i < 6; i++) begin
      cur_src = T_SRC[i];
      boot(T_SEL[i], T_STC[i], 1'b0, 1'b1);
      chk("source", 8'(selected_source), 8'(T_SRC[i]));
      ok("reset ticks", ticks >= T_TICK[i] && ticks <= T_TICK[i] + 8);
      nap(T_WAKE[i]);
    end
  endtask : sources

  task automatic prescale;
    // Run-time frequency change goes through the prescaler with the armed write pair.
    wr(8'h61, 8'h80);
    wr(8'h61, 8'h01);
    rd(8'h61, rd_val);
    chk("prescaler", rd_val, 8'h01);
    div_chk(2);
    wr(8'h61, 8'h02);
    rd(8'h61, rd_val);
    chk("unarmed write", rd_val, 8'h01);
    // An arming write left unused must lapse, so a late field write is ignored.
    wr(8'h61, 8'h80);
    rd(8'h61, rd_val);
    chk("armed", rd_val, 8'h81);
    repeat (3) @(posedge clk);
    wr(8'h61, 8'h02);
    rd(8'h61, rd_val);
    chk("expired arm", rd_val, 8'h01);
  endtask : prescale

  initial begin
    srst = 1'b1;
    fuse_valid = 1'b0;
    clock_source_select_fuses = 4'h0;
    startup_time_code = 2'h0;
    divide_by_eight_fuse = 1'b0;
    sleep_req = 1'b0;
    wake_req = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    errors = 0;
    check_count = 0;
    cur_src = SRC_RC;
    factory();
    trim_ext();
    sources();
    prescale();
    conclude();
  end
endmodule : tb
